// ==== hw/sbx_serial_bit_op_executor.sv ====
// Serial bit operation executor: accumulator, serial adder, counters, Avalon slave
// Functional notes
// (RULE1) Add-one adds two to the select power
// (RULE2) Add-one drops top carry, overflow untouched
// (RULE3) Execute start loads inverted select into counter
// (RULE4) Add-one and toggle rotate, counter advances each shift
// (RULE5) Counter at 37 octal gates a one in
// (RULE6) Add-one carry ripples into higher bits
// (RULE7) Rotation stops after exactly 24 shifts
// (RULE8) Toggle inverts only the selected bit
// (RULE9) Toggle select above 23 leaves accumulator unchanged
// (RULE10) Toggle holds carry flip-flop cleared
// (RULE11) Count operations start with counter cleared
// (RULE12) Ones count: second input off, carry clear
// (RULE13) Ones count advances per one, stops at zero
// (RULE14) All ones gives count of 24
// (RULE15) Software saves count before next group operation
// (RULE16) Zeros count: inverted bit, carry set, unchanged
// (RULE17) Zeros count advances per zero, stops at one
// (RULE18) All zeros gives count of 24
// (RULE19) Six sequence clocks, then delay counts to 30 octal
// (RULE20) Opcode 05 selects group; no memory request
// (RULE21) Count enable set at each execute start
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps

module sbx_serial_bit_op_executor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic busy
);

    sbx_pkg::sbx_state_t state;
    sbx_pkg::sbx_state_t next_state;
    sbx_pkg::sbx_op_t op;
    sbx_pkg::sbx_op_t next_op;
    sbx_pkg::sbx_instr_t instr;
    sbx_pkg::sbx_instr_t next_instr;
    logic [23:0] acc;
    logic [4:0] pos;
    logic [4:0] delay;
    logic [2:0] seq;
    logic carry_flag;
    logic count_enable_flag;
    logic overflow_flag;
    logic badCmd;

    // Bus handshake: one wait cycle per access, the access completes when low
    logic accessReq;
    logic rdNow;
    logic wrNow;
    logic [31:0] byteMask;
    assign accessReq = avs_read | avs_write;
    assign rdNow = avs_read & ~avs_waitrequest;
    assign wrNow = avs_write & ~avs_waitrequest;
    assign byteMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Register write decode; writes to instruction or accumulator are dropped
    // while busy so software cannot corrupt a rotation in flight
    logic idle;
    logic wrInstr;
    logic wrAcc;
    logic wrStatus;
    logic [31:0] instrMerged;
    logic [31:0] accMerged;
    assign idle = (state == sbx_pkg::SBX_IDLE);
    assign wrInstr = wrNow & idle & (avs_address == sbx_pkg::REG_INSTR);
    assign wrAcc = wrNow & idle & (avs_address == sbx_pkg::REG_ACC);
    assign wrStatus = wrNow & (avs_address == sbx_pkg::REG_STATUS);
    assign instrMerged = ({8'h00, instr} & ~byteMask) | (avs_writedata & byteMask);
    assign accMerged = ({8'h00, acc} & ~byteMask) | (avs_writedata & byteMask);
    assign next_instr = sbx_pkg::sbx_instr_t'(instrMerged[23:0]);

    // Operation decode of the freshly written word; only group 05 runs, and it
    // never asks for memory because the block has no memory port at all
    logic isGroup;
    logic selOnes;
    assign isGroup = (next_instr.opcode == sbx_pkg::OPC_BIT_GROUP); // RULE20
    assign selOnes = (next_instr.sel == sbx_pkg::SEL_ALL_ONES);
    assign next_op = !isGroup ? sbx_pkg::SBX_OP_NONE :
        (next_instr.micro == sbx_pkg::MC_ADD_ONE) ? sbx_pkg::SBX_OP_ADD_ONE :
        (next_instr.micro == sbx_pkg::MC_TOGGLE) ? sbx_pkg::SBX_OP_TOGGLE :
        (next_instr.micro == sbx_pkg::MC_CNT_ONES && selOnes) ? sbx_pkg::SBX_OP_CNT_ONES :
        (next_instr.micro == sbx_pkg::MC_CNT_ZEROS && selOnes) ? sbx_pkg::SBX_OP_CNT_ZEROS :
        sbx_pkg::SBX_OP_NONE;

    logic start;
    logic rejected;
    assign start = wrInstr & (next_op != sbx_pkg::SBX_OP_NONE);
    assign rejected = wrInstr & (next_op == sbx_pkg::SBX_OP_NONE);

    // Operation classes
    logic opAdd;
    logic opTog;
    logic opOnes;
    logic opZeros;
    assign opAdd = (op == sbx_pkg::SBX_OP_ADD_ONE);
    assign opTog = (op == sbx_pkg::SBX_OP_TOGGLE);
    assign opOnes = (op == sbx_pkg::SBX_OP_CNT_ONES);
    assign opZeros = (op == sbx_pkg::SBX_OP_CNT_ZEROS);

    // Serial adder around the low accumulator bit
    logic shifting;
    logic lowBit;
    logic posAtLow;
    logic firstIn;
    logic adder_second_input_gate_low;
    logic adder_second_input_gate_high;
    logic secondIn;
    logic sumBit;
    logic carryOut;
    assign shifting = (state == sbx_pkg::SBX_SHIFT);
    assign lowBit = acc[0];
    assign posAtLow = (pos == sbx_pkg::POS_AT_LOW);
    // Zeros count feeds the inverted bit; the held carry restores it
    assign firstIn = opZeros ? ~lowBit : lowBit; // RULE16
    // At the selected bit the low gate opens if it is one, the high gate if it is zero; counts keep both shut
    assign adder_second_input_gate_low = posAtLow & (opAdd | opTog) & lowBit; // RULE5 RULE12
    assign adder_second_input_gate_high = posAtLow & (opAdd | opTog) & ~lowBit; // RULE5 RULE12
    assign secondIn = adder_second_input_gate_low | adder_second_input_gate_high;
    assign sumBit = firstIn ^ secondIn ^ carry_flag; // RULE1 RULE8
    assign carryOut = (firstIn & secondIn) | (firstIn & carry_flag) | (secondIn & carry_flag);

    // Carry for the next shift: add-one ripples, toggle and ones count hold it
    // clear, zeros count holds it set
    logic next_carry;
    assign next_carry = opAdd ? carryOut : opZeros; // RULE6 RULE10 RULE12 RULE16

    // Position counter advance and count-enable clear terms
    logic posAdvance;
    logic enableClear;
    assign posAdvance = (opAdd | opTog) |
                        (opOnes & count_enable_flag & lowBit) |
                        (opZeros & count_enable_flag & ~lowBit); // RULE4 RULE13 RULE17
    assign enableClear = (opOnes & ~lowBit) | (opZeros & lowBit); // RULE13 RULE17

    // Sequencer: six sequence clocks, then one shift per clock until 24 done
    always_comb begin
        next_state = state;
        case (state)
            sbx_pkg::SBX_IDLE: begin
                if (start) begin
                    next_state = sbx_pkg::SBX_SEQ;
                end
            end
            sbx_pkg::SBX_SEQ: begin
                if (seq == sbx_pkg::SEQ_LAST) begin
                    next_state = sbx_pkg::SBX_SHIFT; // RULE19
                end
            end
            sbx_pkg::SBX_SHIFT: begin
                if (delay == sbx_pkg::SHIFT_LAST) begin
                    next_state = sbx_pkg::SBX_IDLE; // RULE7 RULE19
                end
            end
            default: begin
                next_state = sbx_pkg::SBX_IDLE;
            end
        endcase
    end

    // State and operation latch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= sbx_pkg::SBX_IDLE;
            op <= sbx_pkg::SBX_OP_NONE;
        end else begin
            state <= next_state;
            if (start) begin
                op <= next_op;
            end
        end
    end

    // Sequence time counter and delay time counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seq <= sbx_pkg::SEQ_RST;
            delay <= sbx_pkg::DELAY_RST;
        end else if (start) begin
            seq <= sbx_pkg::SEQ_RST;
            delay <= sbx_pkg::DELAY_RST;
        end else begin
            seq <= (state == sbx_pkg::SBX_SEQ) ? seq + 3'h1 : seq; // RULE19
            delay <= shifting ? delay + 5'h01 : delay; // RULE19
        end
    end

    // Accumulator: rotates right through the adder, sum enters the top bit.
    // The carry left after the last shift is simply dropped, and an out of
    // range select never meets the low end, so the word comes back intact.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= sbx_pkg::ACC_RST;
        end else if (shifting) begin
            acc <= {sumBit, acc[23:1]}; // RULE2 RULE4 RULE7 RULE9
        end else if (wrAcc) begin
            acc <= accMerged[23:0];
        end
    end

    // Position counter, carry and count-enable flip-flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pos <= sbx_pkg::POS_RST;
            carry_flag <= 1'b0;
            count_enable_flag <= 1'b0;
        end else if (start) begin
            pos <= ~next_instr.sel; // RULE3 RULE11
            carry_flag <= (next_op == sbx_pkg::SBX_OP_CNT_ZEROS); // RULE16
            count_enable_flag <= 1'b1; // RULE21
        end else if (shifting) begin
            pos <= posAdvance ? pos + 5'h01 : pos; // RULE4 RULE14 RULE18
            carry_flag <= next_carry;
            count_enable_flag <= count_enable_flag & ~enableClear; // RULE13 RULE17
        end
    end

    // Instruction register, overflow flag and rejected-command flag.
    // Overflow is software-owned; execution never touches it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instr <= sbx_pkg::sbx_instr_t'(sbx_pkg::INSTR_RST);
            overflow_flag <= 1'b0;
            badCmd <= 1'b0;
        end else begin
            if (wrInstr) begin
                instr <= next_instr;
            end
            if (wrStatus && avs_byteenable[0]) begin
                overflow_flag <= avs_writedata[sbx_pkg::ST_OVF_BIT]; // RULE2
            end
            // A new rejection wins over a clear in the same cycle
            if (rejected) begin
                badCmd <= 1'b1;
            end else if (wrStatus && avs_byteenable[0] && avs_writedata[sbx_pkg::ST_BAD_BIT]) begin
                badCmd <= 1'b0;
            end
        end
    end

    // Read data selection; unmapped words read as zero
    logic [31:0] statusWord;
    logic [31:0] readMux;
    assign statusWord = {29'h0000_0000, badCmd, overflow_flag, ~idle};
    assign readMux = (avs_address == sbx_pkg::REG_INSTR) ? {8'h00, instr} :
                     (avs_address == sbx_pkg::REG_ACC) ? {8'h00, acc} :
                     (avs_address == sbx_pkg::REG_POS) ? {27'h000_0000, pos} :
                     (avs_address == sbx_pkg::REG_STATUS) ? statusWord :
                     32'h0000_0000;

    // Bus response: waitrequest drops for exactly one cycle per access, with
    // read data captured on the same edge so both come straight from flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(accessReq & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= readMux;
            end
        end
    end

    // Busy output mirrors the execute state one cycle late-free via next_state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else begin
            busy <= (next_state != sbx_pkg::SBX_IDLE);
        end
    end

endmodule : sbx_serial_bit_op_executor

// ==== inc/sbx_pkg.sv ====
// Shared constants and types for the serial bit operation executor
package sbx_pkg;

    // Register word index on the Avalon slave (byte address is four times this)
    localparam logic [2:0] REG_INSTR = 3'h0;
    localparam logic [2:0] REG_ACC = 3'h1;
    localparam logic [2:0] REG_POS = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;

    // Status register field positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_OVF_BIT = 1;
    localparam int ST_BAD_BIT = 2;

    // Reset values
    localparam logic [23:0] ACC_RST = 24'h00_0000;
    localparam logic [23:0] INSTR_RST = 24'h00_0000;
    localparam logic [4:0] POS_RST = 5'h00;

    // Instruction decode
    localparam logic [5:0] OPC_BIT_GROUP = 6'h05;
    localparam logic [9:0] MC_ADD_ONE = 10'h070;
    localparam logic [9:0] MC_TOGGLE = 10'h270;
    // Count codes keep the shift-inhibit bit (lowest micro bit) clear
    localparam logic [9:0] MC_CNT_ONES = 10'h042;
    localparam logic [9:0] MC_CNT_ZEROS = 10'h382;
    localparam logic [4:0] SEL_ALL_ONES = 5'h1f;

    // Timing counts: position counter value that puts the selected bit at the
    // low end (octal 37), six sequence clocks, and 24 shifts (octal 30)
    localparam logic [4:0] POS_AT_LOW = 5'h1f;
    localparam logic [2:0] SEQ_LAST = 3'h5;
    localparam logic [4:0] SHIFT_LAST = 5'h17;
    localparam logic [4:0] DELAY_RST = 5'h00;
    localparam logic [2:0] SEQ_RST = 3'h0;

    typedef enum logic [1:0] {
        SBX_IDLE,
        SBX_SEQ,
        SBX_SHIFT
    } sbx_state_t;

    typedef enum logic [2:0] {
        SBX_OP_NONE,
        SBX_OP_ADD_ONE,
        SBX_OP_TOGGLE,
        SBX_OP_CNT_ONES,
        SBX_OP_CNT_ZEROS
    } sbx_op_t;

    // Instruction word fields, most significant first
    typedef struct packed {
        logic [5:0] opcode;
        logic [2:0] index;
        logic [9:0] micro;
        logic [4:0] sel;
    } sbx_instr_t;

endpackage : sbx_pkg

// ==== testbench/sbx_monitor.sv ====
// Checker for bus handshake and execution timing of the bit executor
`timescale 1ns/100ps
module sbx_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic busy
);
    logic [5:0] busyCnt;
    logic takeInstr;
    // Counts busy cycles so the run length can be judged at the falling edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            busyCnt <= 6'h00;
        else
            busyCnt <= busy ? busyCnt + 6'h01 : 6'h00;
    end
    // Write to the instruction word accepted while idle
    assign takeInstr = avs_write && !avs_waitrequest && !busy
        && avs_address == sbx_pkg::REG_INSTR && avs_byteenable == 4'hf;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    property p_wait_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    property p_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered next cycle");
    property p_pos_width;
        avs_read && !avs_waitrequest && avs_address == sbx_pkg::REG_POS
            |-> avs_readdata[31:5] == 27'h000_0000;
    endproperty
    a_pos_width: assert property (p_pos_width) else $error("counter read too wide");
    property p_run_len; $fell(busy) |-> busyCnt == 6'h1e; endproperty
    a_run_len: assert property (p_run_len) else $error("run not 30 cycles");
    property p_run_max; busy |-> busyCnt < 6'h1e; endproperty
    a_run_max: assert property (p_run_max) else $error("run exceeds 30 cycles");
    property p_start;
        takeInstr && avs_writedata[23:18] == sbx_pkg::OPC_BIT_GROUP
            && avs_writedata[14:5] == sbx_pkg::MC_ADD_ONE |=> busy [*8];
    endproperty
    a_start: assert property (p_start) else $error("valid instruction did not run");
    property p_bad_op;
        takeInstr && avs_writedata[23:18] != sbx_pkg::OPC_BIT_GROUP |=> !busy;
    endproperty
    a_bad_op: assert property (p_bad_op) else $error("foreign opcode ran");
    c_run: cover property ($fell(busy));
    c_read: cover property (avs_read && !avs_waitrequest);
    c_bad: cover property (takeInstr && avs_writedata[23:18] != sbx_pkg::OPC_BIT_GROUP);
endmodule : sbx_monitor

// ==== testbench/tb.sv ====
// Self-checking bench for the serial bit operation executor
`timescale 1ns/100ps
module tb;
    logic clk, rst_b, avs_read, avs_write, busy, avs_waitrequest;
    logic [2:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic [4:0] sels [5] = '{5'h00, 5'h05, 5'h17, 5'h18, 5'h1e};
    int mismatches = 0;
    int samples_checked = 0;
    sbx_serial_bit_op_executor uut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .busy(busy));
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask : chk
    // One Avalon access; request held until waitrequest is sampled low
    task bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk("bus answer", 32'h0000_0000, {31'h0000_0000, n >= 50});
    endtask : bus
    task rdchk(input string nm, input logic [2:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rd);
    endtask : rdchk
    function automatic logic [31:0] wd(logic [5:0] op, logic [9:0] mc, logic [4:0] s);
        return {8'h00, op, 3'h0, mc, s};
    endfunction : wd
    // Load the accumulator, run one operation, count busy cycles, read results
    task t_op(input logic [9:0] mc, input logic [4:0] s, input logic [23:0] a,
        input logic [23:0] ea, input logic [4:0] ep);
        int n;
        n = 0;
        bus(1'b1, sbx_pkg::REG_ACC, {8'h00, a});
        bus(1'b1, sbx_pkg::REG_INSTR, wd(sbx_pkg::OPC_BIT_GROUP, mc, s));
        repeat (40) begin
            @(posedge clk);
            if (busy === 1'b1)
                n++;
        end
        chk("busy cycles", 32'h0000_001e, 32'(n));
        rdchk("acc", sbx_pkg::REG_ACC, {8'h00, ea});
        // Counter is saved right after each run, before the next group operation
        rdchk("pos", sbx_pkg::REG_POS, {27'h000_0000, ep});
    endtask : t_op
    task t_reset;
        rdchk("acc rst", sbx_pkg::REG_ACC, 32'h0000_0000);
        rdchk("pos rst", sbx_pkg::REG_POS, 32'h0000_0000);
        rdchk("status rst", sbx_pkg::REG_STATUS, 32'h0000_0000);
    endtask : t_reset
    // Boundary selects, carry ripple into and past the top bit, select above 23
    task t_add_toggle;
        logic [23:0] a;
        a = 24'ha5_a5a5;
        bus(1'b1, sbx_pkg::REG_STATUS, 32'h0000_0002);
        for (int i = 0; i < 5; i++) begin
            t_op(sbx_pkg::MC_ADD_ONE, sels[i], a,
                sels[i] > 5'h17 ? a : a + (24'h00_0001 << sels[i]), 5'h17 - sels[i]);
            t_op(sbx_pkg::MC_TOGGLE, sels[i], a,
                sels[i] > 5'h17 ? a : a ^ (24'h00_0001 << sels[i]), 5'h17 - sels[i]);
        end
        t_op(sbx_pkg::MC_ADD_ONE, 5'h00, 24'hff_ffff, 24'h00_0000, 5'h17);
        rdchk("ovf kept", sbx_pkg::REG_STATUS, 32'h0000_0002);
    endtask : t_add_toggle
    task t_counts;
        t_op(sbx_pkg::MC_CNT_ONES, 5'h1f, 24'h00_0007, 24'h00_0007, 5'h03);
        t_op(sbx_pkg::MC_CNT_ONES, 5'h1f, 24'hff_ffff, 24'hff_ffff, 5'h18);
        t_op(sbx_pkg::MC_CNT_ONES, 5'h1f, 24'hff_fffe, 24'hff_fffe, 5'h00);
        t_op(sbx_pkg::MC_CNT_ZEROS, 5'h1f, 24'h00_0100, 24'h00_0100, 5'h08);
        t_op(sbx_pkg::MC_CNT_ZEROS, 5'h1f, 24'h00_0000, 24'h00_0000, 5'h18);
        t_op(sbx_pkg::MC_CNT_ZEROS, 5'h1f, 24'h80_0000, 24'h80_0000, 5'h17);
        t_op(sbx_pkg::MC_CNT_ZEROS, 5'h1f, 24'h00_0001, 24'h00_0001, 5'h00);
    endtask : t_counts
    // Writes arriving mid-run are dropped; status shows busy meanwhile
    task t_busy_write;
        bus(1'b1, sbx_pkg::REG_ACC, 32'h0000_0000);
        bus(1'b1, sbx_pkg::REG_INSTR, wd(sbx_pkg::OPC_BIT_GROUP, sbx_pkg::MC_TOGGLE, 5'h03));
        bus(1'b1, sbx_pkg::REG_ACC, 32'h00ff_ffff);
        bus(1'b1, sbx_pkg::REG_INSTR, wd(sbx_pkg::OPC_BIT_GROUP, sbx_pkg::MC_CNT_ONES, 5'h1f));
        rdchk("status busy", sbx_pkg::REG_STATUS, 32'h0000_0003);
        repeat (40) @(posedge clk);
        rdchk("acc kept", sbx_pkg::REG_ACC, 32'h0000_0008);
        rdchk("pos kept", sbx_pkg::REG_POS, 32'h0000_0014);
    endtask : t_busy_write
    // Foreign opcode and unknown microcode refused; unmapped words read zero
    task t_refused;
        bus(1'b1, sbx_pkg::REG_INSTR, wd(6'h06, sbx_pkg::MC_ADD_ONE, 5'h00));
        rdchk("bad op", sbx_pkg::REG_STATUS, 32'h0000_0006);
        bus(1'b1, sbx_pkg::REG_STATUS, 32'h0000_0006);
        bus(1'b1, sbx_pkg::REG_INSTR, wd(sbx_pkg::OPC_BIT_GROUP, 10'h3ff, 5'h00));
        rdchk("bad micro", sbx_pkg::REG_STATUS, 32'h0000_0006);
        rdchk("acc idle", sbx_pkg::REG_ACC, 32'h0000_0008);
        rdchk("instr", sbx_pkg::REG_INSTR, wd(sbx_pkg::OPC_BIT_GROUP, 10'h3ff, 5'h00));
        // Single lane write merges into the accumulator, other lanes kept
        avs_byteenable <= 4'h1;
        bus(1'b1, sbx_pkg::REG_ACC, 32'hffff_ff5a);
        avs_byteenable <= 4'hf;
        rdchk("acc lane", sbx_pkg::REG_ACC, 32'h0000_005a);
        bus(1'b1, 3'h5, 32'hffff_ffff);
        rdchk("unmapped", 3'h5, 32'h0000_0000);
    endtask : t_refused
    // Free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Main sequence
    initial begin
        rst_b = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 3'h0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_add_toggle();
        t_counts();
        t_busy_write();
        t_refused();
        give_verdict();
    end
    // Hang guard, well beyond the expected run length
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
endmodule : tb
bind sbx_serial_bit_op_executor sbx_monitor u_mon (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy));
